// *** fbr_host.sv ***
// fbr_host: host model issuing one register request at a time.
// assumes the answer stands in the cycle after the taking edge.
`timescale 1ns/1ps
module fbr_host
   import fbr_pkg::*;
(
   // clock
   input wire logic clk_sys,
   // register request and answer
   output fbr_mb_req_t mb_req,
   input wire fbr_mb_rsp_t mb_rsp
);
   initial mb_req = '0;
   task automatic xfer(input logic w, input logic [15:0] a, d,
      output logic [15:0] rd, output logic er, output logic ok);
      @(posedge clk_sys) #2;
      mb_req = '{1'h1, w, a, d};
      @(posedge clk_sys) #2;
      // released lines show the inverse, not the last value
      mb_req = '{1'h0, ~w, ~a, ~d};
      ok = mb_rsp.ack;
      rd = mb_rsp.rdata;
      er = mb_rsp.err;
   endtask : xfer
endmodule : fbr_host

// *** fbr_pkg.sv ***
// fbr_pkg: register map, codes, reset values and carriers of the
// fieldbus status and configuration bank.
// assumes one 16-bit register access per request from the host side.
package fbr_pkg;

   // register addresses (16-bit register numbers)
   localparam logic [15:0] FBR_ADR_LINK_STATE = 16'h4001;
   localparam logic [15:0] FBR_ADR_NODE_STATE = 16'h4002;
   localparam logic [15:0] FBR_ADR_MAKER_HI = 16'h4003;
   localparam logic [15:0] FBR_ADR_MAKER_LO = 16'h4004;
   localparam logic [15:0] FBR_ADR_BUSVER_HI = 16'h4007;
   localparam logic [15:0] FBR_ADR_BUSVER_LO = 16'h4008;
   localparam logic [15:0] FBR_ADR_FIRMWARE = 16'h4009;
   localparam logic [15:0] FBR_ADR_SERIAL_HI = 16'h400A;
   localparam logic [15:0] FBR_ADR_SERIAL_LO = 16'h400B;
   localparam logic [15:0] FBR_ADR_NODE_ADDR = 16'h400C;
   localparam logic [15:0] FBR_ADR_ACT_RATE = 16'h400F;
   localparam logic [15:0] FBR_ADR_STO_RATE = 16'h4010;
   localparam logic [15:0] FBR_ADR_CFG_HI = 16'h4011;
   localparam logic [15:0] FBR_ADR_CFG_LO = 16'h4012;

   // reset values
   localparam logic [15:0] FBR_RST_STO_RATE = 16'h0000;
   localparam logic [31:0] FBR_RST_CFG = 32'h0000_0009;
   localparam logic [15:0] FBR_ZERO16 = 16'h0000;

   // active bit rate answers
   localparam logic [15:0] FBR_RATE_UNKNOWN = 16'h0000;
   localparam logic [15:0] FBR_RATE_NO_BUS = 16'hFFFF;
   localparam logic [3:0] FBR_RATE_AUTO = 4'h0;
   localparam logic [3:0] FBR_RATE_MAX = 4'h8;

   // node address limits
   localparam logic [6:0] FBR_ADDR_NONE = 7'h00;

   // field of the configuration word
   localparam int FBR_CFG_SRC_LSB = 0;

   // bus status codes
   typedef enum logic [1:0] {
      FBR_LINK_UNDEF = 2'h0,
      FBR_LINK_RUN = 2'h1,
      FBR_LINK_BUSOFF = 2'h2,
      FBR_LINK_BAD_SET = 2'h3
   } fbr_link_t;

   // node protocol state codes
   typedef enum logic [2:0] {
      FBR_NODE_INIT = 3'h0,
      FBR_NODE_ERROR = 3'h1,
      FBR_NODE_STOPPED = 3'h2,
      FBR_NODE_STARTUP = 3'h3,
      FBR_NODE_OPER = 3'h4
   } fbr_node_t;

   // address source selection, configuration bits 1:0
   typedef enum logic [1:0] {
      FBR_SRC_STORED = 2'h0,
      FBR_SRC_SHIFT = 2'h1,
      FBR_SRC_LSS = 2'h2,
      FBR_SRC_BAD = 2'h3
   } fbr_src_t;

   // host register request
   typedef struct packed {
      logic req;
      logic wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } fbr_mb_req_t;

   // host register answer
   typedef struct packed {
      logic ack;
      logic err;
      logic [15:0] rdata;
   } fbr_mb_rsp_t;

   // persistent image, kept by outside storage
   typedef struct packed {
      logic [31:0] maker;
      logic [31:0] serial;
      logic [15:0] sto_rate;
      logic [31:0] cfg;
   } fbr_nv_t;

   // live state from the fieldbus engine
   typedef struct packed {
      fbr_link_t link;
      fbr_node_t node;
      logic bus_connected;
      logic rate_known;
      logic [3:0] rate;
      logic [6:0] lss_addr;
      logic [3:0] lss_rate;
   } fbr_eng_t;

   // applied node setting
   typedef struct packed {
      logic [6:0] addr;
      logic [3:0] rate;
      logic invalid;
   } fbr_apply_t;

   function automatic logic fbr_rate_ok(input logic [15:0] r);
      fbr_rate_ok = (r <= {12'h000, FBR_RATE_MAX});
   endfunction : fbr_rate_ok

endpackage : fbr_pkg

// *** fbr_regs.sv ***
// fbr_regs: fieldbus status and configuration register bank.
// assumes host register requests, engine state, shift register port
// and storage image all come from logic on clk_sys.
//
// Overview of operation
// - bus status reads undefined, run, bus-off, bad setting
// - node state reads init, error, stopped, start-up, operation
// - maker number writable, persistent, high word first
// - bus version read-only, high word first, zero default
// - firmware revision read-only fixed value
// - serial number writable, persistent, high word first
// - active node address shows address in use
// - LSS without network shows zero, flags invalid
// - active rate: unknown zero, codes 1-8, no bus FFFF
// - stored rate accepts 0-8, persistent, default 0
// - stored rate applies only for register source
// - config bits 1:0 select address source
// - config word writable, persistent, default 00000009
`timescale 1ns/1ps
module fbr_regs
   import fbr_pkg::*;
#(
   parameter logic [31:0] MAKER_DEFAULT = 32'h0000_1234, // arbitrary value
   parameter logic [31:0] SERIAL_DEFAULT = 32'h0000_0001, // arbitrary value
   parameter logic [15:0] FIRMWARE_REV = 16'h0100, // arbitrary value
   parameter logic [31:0] BUS_VERSION = 32'h0000_0000
)
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // host register access
   input wire fbr_mb_req_t mb_req,
   output fbr_mb_rsp_t mb_rsp_q,
   // fieldbus engine state
   input wire fbr_eng_t eng,
   // stored node address and shift register port
   input wire logic [6:0] stored_node_addr,
   input wire logic [6:0] shift_register_port_addr,
   input wire logic shift_register_port_valid,
   // applied setting toward the engine
   output fbr_apply_t apply_q,
   // config debug port: invalid setting flag
   output logic config_debug_port_invalid_q,
   // persistent storage
   input wire logic nv_load,
   input wire fbr_nv_t nv_image,
   output fbr_nv_t nv_image_q,
   output logic nv_store_q
);

   typedef struct packed {
      fbr_nv_t nv;
      fbr_mb_rsp_t rsp;
      fbr_apply_t apply;
      logic store;
   } fbr_state_t;

   localparam fbr_nv_t NV_RESET = '{
      maker: MAKER_DEFAULT,
      serial: SERIAL_DEFAULT,
      sto_rate: FBR_RST_STO_RATE,
      cfg: FBR_RST_CFG
   };

   fbr_state_t s_q;
   fbr_state_t s_d;
   fbr_apply_t sel;
   fbr_src_t src;
   logic [15:0] rd_val;
   logic rd_hit;
   logic ro_hit;

   // source chosen by the stored configuration word
   assign src = fbr_src_t'(s_q.nv.cfg[FBR_CFG_SRC_LSB +: 2]);

   fbr_src_sel u_sel (
      .src(src),
      .stored_addr(stored_node_addr),
      .stored_rate(s_q.nv.sto_rate),
      .shift_addr(shift_register_port_addr),
      .shift_valid(shift_register_port_valid),
      .lss_addr(eng.lss_addr),
      .lss_rate(eng.lss_rate),
      .bus_connected(eng.bus_connected),
      .apply(sel)
   );

   // read decode
   always_comb begin
      rd_val = FBR_ZERO16;
      rd_hit = 1'b1;
      ro_hit = 1'b0;
      if (mb_req.addr == FBR_ADR_LINK_STATE) begin
         ro_hit = 1'b1;
         if (s_q.apply.invalid) begin
            rd_val = {14'h0000, FBR_LINK_BAD_SET};
         end else begin
            rd_val = {14'h0000, eng.link};
         end
      end else if (mb_req.addr == FBR_ADR_NODE_STATE) begin
         ro_hit = 1'b1;
         rd_val = {13'h0000, eng.node};
      end else if (mb_req.addr == FBR_ADR_MAKER_HI) begin
         rd_val = s_q.nv.maker[31:16];
      end else if (mb_req.addr == FBR_ADR_MAKER_LO) begin
         rd_val = s_q.nv.maker[15:0];
      end else if (mb_req.addr == FBR_ADR_BUSVER_HI) begin
         ro_hit = 1'b1;
         rd_val = BUS_VERSION[31:16];
      end else if (mb_req.addr == FBR_ADR_BUSVER_LO) begin
         ro_hit = 1'b1;
         rd_val = BUS_VERSION[15:0];
      end else if (mb_req.addr == FBR_ADR_FIRMWARE) begin
         ro_hit = 1'b1;
         rd_val = FIRMWARE_REV;
      end else if (mb_req.addr == FBR_ADR_SERIAL_HI) begin
         rd_val = s_q.nv.serial[31:16];
      end else if (mb_req.addr == FBR_ADR_SERIAL_LO) begin
         rd_val = s_q.nv.serial[15:0];
      end else if (mb_req.addr == FBR_ADR_NODE_ADDR) begin
         ro_hit = 1'b1;
         rd_val = {9'h000, s_q.apply.addr};
      end else if (mb_req.addr == FBR_ADR_ACT_RATE) begin
         ro_hit = 1'b1;
         if (!eng.bus_connected) begin
            rd_val = FBR_RATE_NO_BUS;
         end else if (!eng.rate_known) begin
            rd_val = FBR_RATE_UNKNOWN;
         end else begin
            rd_val = {12'h000, eng.rate};
         end
      end else if (mb_req.addr == FBR_ADR_STO_RATE) begin
         rd_val = s_q.nv.sto_rate;
      end else if (mb_req.addr == FBR_ADR_CFG_HI) begin
         rd_val = s_q.nv.cfg[31:16];
      end else if (mb_req.addr == FBR_ADR_CFG_LO) begin
         rd_val = s_q.nv.cfg[15:0];
      end else begin
         rd_hit = 1'b0;
      end
   end

   // next state
   always_comb begin
      s_d = s_q;
      s_d.rsp.ack = 1'b0;
      s_d.rsp.err = 1'b0;
      s_d.store = 1'b0;
      s_d.apply = sel;
      if (nv_load) begin
         // storage image restores persistent words after power-up
         s_d.nv = nv_image;
         if (!fbr_rate_ok(nv_image.sto_rate)) begin
            s_d.nv.sto_rate = FBR_RST_STO_RATE;
         end
      end
      if (mb_req.req) begin
         s_d.rsp.ack = 1'b1;
         s_d.rsp.rdata = rd_val;
         s_d.rsp.err = !rd_hit;
         if (mb_req.wr) begin
            s_d.rsp.rdata = FBR_ZERO16;
            if (rd_hit && !ro_hit) begin
               s_d.store = 1'b1;
            end
            // read-only words ignore writes, answer without error
            if (mb_req.addr == FBR_ADR_MAKER_HI) begin
               s_d.nv.maker[31:16] = mb_req.wdata;
            end else if (mb_req.addr == FBR_ADR_MAKER_LO) begin
               s_d.nv.maker[15:0] = mb_req.wdata;
            end else if (mb_req.addr == FBR_ADR_SERIAL_HI) begin
               s_d.nv.serial[31:16] = mb_req.wdata;
            end else if (mb_req.addr == FBR_ADR_SERIAL_LO) begin
               s_d.nv.serial[15:0] = mb_req.wdata;
            end else if (mb_req.addr == FBR_ADR_STO_RATE) begin
               if (fbr_rate_ok(mb_req.wdata)) begin
                  s_d.nv.sto_rate = mb_req.wdata;
               end else begin
                  s_d.rsp.err = 1'b1;
                  s_d.store = 1'b0;
               end
            end else if (mb_req.addr == FBR_ADR_CFG_HI) begin
               s_d.nv.cfg[31:16] = mb_req.wdata;
            end else if (mb_req.addr == FBR_ADR_CFG_LO) begin
               s_d.nv.cfg[15:0] = mb_req.wdata;
            end else if (ro_hit) begin
               s_d.rsp.err = 1'b0;
            end
         end
      end
   end

   // state register
   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         s_q.nv <= NV_RESET;
         s_q.rsp <= '0;
         s_q.apply <= '0;
         s_q.store <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign mb_rsp_q = s_q.rsp;
   assign apply_q = s_q.apply;
   assign config_debug_port_invalid_q = s_q.apply.invalid;
   assign nv_image_q = s_q.nv;
   assign nv_store_q = s_q.store;

endmodule : fbr_regs

// *** fbr_regs_properties.sv ***
// fbr_regs_properties: timing checks of the register bank.
// assumes the bind in the bench top file; one clock domain.
`timescale 1ns/1ps
module fbr_regs_properties
   import fbr_pkg::*;
(
   // clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // host side
   input wire fbr_mb_req_t mb_req,
   input wire fbr_mb_rsp_t mb_rsp_q,
   // engine and ports
   input wire fbr_eng_t eng,
   input wire logic [6:0] stored_node_addr,
   input wire logic [6:0] shift_register_port_addr,
   input wire logic shift_register_port_valid,
   input wire fbr_apply_t apply_q,
   input wire logic config_debug_port_invalid_q,
   // storage
   input wire logic nv_load,
   input wire fbr_nv_t nv_image,
   input wire fbr_nv_t nv_image_q,
   input wire logic nv_store_q
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   logic rd;
   logic wr;
   assign rd = mb_req.req && !mb_req.wr;
   assign wr = mb_req.req && mb_req.wr && !nv_load;
   a_ack_follows: assert property (mb_req.req |=> mb_rsp_q.ack)
      else $error("no answer after request");
   a_no_stray_ack: assert property (!mb_req.req |=> !mb_rsp_q.ack)
      else $error("answer without request");
   a_link_read: assert property (
      rd && mb_req.addr == FBR_ADR_LINK_STATE |=> mb_rsp_q.rdata ==
      ($past(apply_q.invalid) ? 16'h0003 : {14'h0, $past(eng.link)}))
      else $error("bus status read wrong");
   a_node_read: assert property (
      rd && mb_req.addr == FBR_ADR_NODE_STATE
      |=> mb_rsp_q.rdata == {13'h0, $past(eng.node)})
      else $error("node state read wrong");
   a_addr_read: assert property (
      rd && mb_req.addr == FBR_ADR_NODE_ADDR
      |=> mb_rsp_q.rdata == {9'h0, $past(apply_q.addr)})
      else $error("node address read wrong");
   a_rate_read: assert property (
      rd && mb_req.addr == FBR_ADR_ACT_RATE |=> mb_rsp_q.rdata ==
      (!$past(eng.bus_connected) ? FBR_RATE_NO_BUS :
      !$past(eng.rate_known) ? FBR_RATE_UNKNOWN : {12'h0, $past(eng.rate)}))
      else $error("bit rate read wrong");
   a_lss_no_net: assert property (
      nv_image_q.cfg[1:0] == FBR_SRC_LSS && !eng.bus_connected
      |=> apply_q.addr == FBR_ADDR_NONE && apply_q.invalid)
      else $error("lss without network not flagged");
   a_stored_src: assert property (
      nv_image_q.cfg[1:0] == FBR_SRC_STORED && stored_node_addr != 7'h00
      |=> apply_q.rate == $past(nv_image_q.sto_rate[3:0]))
      else $error("stored rate not applied");
   a_bad_rate_err: assert property (
      wr && mb_req.addr == FBR_ADR_STO_RATE && mb_req.wdata > 16'h0008
      |=> mb_rsp_q.err && $stable(nv_image_q.sto_rate))
      else $error("bad stored rate accepted");
   a_ro_write_quiet: assert property (
      wr && mb_req.addr inside {16'h4001, 16'h4002, 16'h4007, 16'h4008,
      16'h4009, 16'h400C, 16'h400F}
      |=> !nv_store_q && !mb_rsp_q.err && $stable(nv_image_q))
      else $error("read-only write had an effect");
   a_maker_write: assert property (
      wr && mb_req.addr == FBR_ADR_MAKER_HI |=> nv_store_q &&
      nv_image_q.maker[31:16] == $past(mb_req.wdata))
      else $error("maker high word not stored");
   c_write: cover property (mb_req.req && mb_req.wr);
   c_read: cover property (rd);
   c_err: cover property (mb_rsp_q.ack && mb_rsp_q.err);
endmodule : fbr_regs_properties

// *** fbr_regs_test.sv ***
// fbr_regs_test: self-checking bench of the register bank.
// assumes fbr_host as register host and the bound checker.
`timescale 1ns/1ps
module fbr_regs_test;
   import fbr_pkg::*;
   localparam logic [31:0] MK = 32'h0000_5A5A; // arbitrary value
   localparam logic [31:0] SN = 32'h0000_0077; // arbitrary value
   localparam logic [15:0] FW = 16'hA5C3; // arbitrary value
   logic clk_sys, nrst, nv_load, sh_v, ok, er, inv_q, nv_store_q;
   logic [6:0] st_a, sh_a;
   logic [15:0] rd;
   fbr_mb_req_t mb_req;
   fbr_mb_rsp_t mb_rsp_q;
   fbr_eng_t eng;
   fbr_apply_t apply_q;
   fbr_nv_t nv_image, nv_image_q;
   int error_cnt, check_count;
   logic [15:0] ro [7] = '{16'h4001, 16'h4002, 16'h4007, 16'h4008,
      16'h4009, 16'h400C, 16'h400F};
   fbr_regs #(.MAKER_DEFAULT(MK), .SERIAL_DEFAULT(SN), .FIRMWARE_REV(FW))
      dut_u (.clk_sys(clk_sys), .nrst(nrst), .mb_req(mb_req),
      .mb_rsp_q(mb_rsp_q), .eng(eng), .stored_node_addr(st_a),
      .shift_register_port_addr(sh_a), .shift_register_port_valid(sh_v),
      .apply_q(apply_q), .config_debug_port_invalid_q(inv_q),
      .nv_load(nv_load), .nv_image(nv_image), .nv_image_q(nv_image_q),
      .nv_store_q(nv_store_q));
   fbr_host host_u (.clk_sys(clk_sys), .mb_req(mb_req), .mb_rsp(mb_rsp_q));
   task automatic report_and_stop();
      $display("errors %0d checks %0d", error_cnt, check_count);
      if (error_cnt == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop
   task automatic chk(input string n, input logic [31:0] s, e);
      check_count++;
      if (s !== e) begin
         error_cnt++;
         $display("ERROR %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic acc(input logic w, input logic [15:0] a, d);
      host_u.xfer(w, a, d, rd, er, ok);
      if (ok !== 1'h1) begin
         error_cnt++;
         $display("ERROR answer at %h expected 1 seen %b", a, ok);
         report_and_stop();
      end
   endtask : acc
   task automatic rdc(input logic [15:0] a, e);
      acc(1'h0, a, 16'h0000);
      chk($sformatf("reg %h", a), rd, e);
   endtask : rdc
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
      #2;
   endtask : step
   task automatic sc_defaults();
      rdc(16'h4010, 16'h0000);
      rdc(16'h4011, 16'h0000);
      rdc(16'h4012, 16'h0009);
      rdc(16'h4007, 16'h0000);
      rdc(16'h4008, 16'h0000);
      rdc(16'h4009, FW);
      rdc(16'h4003, MK[31:16]);
      rdc(16'h4004, MK[15:0]);
      rdc(16'h400B, SN[15:0]);
   endtask : sc_defaults
   task automatic sc_status();
      for (int i = 0; i < 3; i++) begin
         eng.link = fbr_link_t'(i);
         rdc(16'h4001, 16'(i));
      end
      for (int i = 0; i < 5; i++) begin
         eng.node = fbr_node_t'(i);
         rdc(16'h4002, 16'(i));
      end
      rdc(16'h400C, 16'h0015);
      eng.bus_connected = 1'h0;
      rdc(16'h400F, 16'hFFFF);
      eng.bus_connected = 1'h1;
      rdc(16'h400F, 16'h0000);
      eng.rate_known = 1'h1;
      for (int i = 1; i < 9; i++) begin
         eng.rate = 4'(i);
         rdc(16'h400F, 16'(i));
      end
   endtask : sc_status
   task automatic sc_words();
      foreach (ro[i]) begin
         acc(1'h1, ro[i], 16'hFFFF);
         chk("ro err", er, 1'h0);
         chk("ro store", nv_store_q, 1'h0);
      end
      rdc(16'h4009, FW);
      acc(1'h0, 16'h4005, 16'h0000);
      chk("unmapped err", er, 1'h1);
      for (int b = 16'h4003; b < 16'h400B; b += 7) begin
         acc(1'h1, 16'(b), 16'hC3A1);
         chk("store", nv_store_q, 1'h1);
         acc(1'h1, 16'(b + 1), 16'h5E0F);
         rdc(16'(b), 16'hC3A1);
      end
      chk("maker", nv_image_q.maker, 32'hC3A1_5E0F);
      chk("serial", nv_image_q.serial, 32'hC3A1_5E0F);
      acc(1'h1, 16'h4010, 16'h0009);
      chk("rate err", er, 1'h1);
      rdc(16'h4010, 16'h0000);
   endtask : sc_words
   task automatic sc_source();
      acc(1'h1, 16'h4010, 16'h0004);
      acc(1'h1, 16'h4012, 16'h0000);
      step(2);
      chk("stored addr", apply_q.addr, 7'h22);
      chk("stored rate", apply_q.rate, 4'h4);
      acc(1'h1, 16'h4012, 16'h0001);
      step(2);
      chk("shift addr", apply_q.addr, 7'h15);
      chk("shift rate", apply_q.rate, 4'h0);
      sh_a = 7'h2B;
      step(2);
      chk("shift port addr", apply_q.addr, 7'h2B);
      sh_v = 1'h0;
      step(2);
      chk("shift invalid", inv_q, 1'h1);
      rdc(16'h4001, 16'h0003);
      rdc(16'h400C, 16'h0000);
      sh_v = 1'h1;
      acc(1'h1, 16'h4012, 16'h0002);
      step(2);
      chk("lss addr", apply_q.addr, 7'h33);
      chk("lss rate", apply_q.rate, 4'h6);
      eng.bus_connected = 1'h0;
      step(2);
      rdc(16'h400C, 16'h0000);
      chk("invalid flag", inv_q, 1'h1);
      acc(1'h1, 16'h4012, 16'h0003);
      eng.bus_connected = 1'h1;
      step(2);
      rdc(16'h4001, 16'h0003);
      nv_image = '{32'h0000_1111, SN, 16'h0009, 32'h1};
      nv_load = 1'h1;
      step(1);
      nv_load = 1'h0;
      rdc(16'h4004, 16'h1111);
      rdc(16'h4010, 16'h0000);
   endtask : sc_source
   task automatic sc_reset();
      acc(1'h1, 16'h4011, 16'h1234);
      rdc(16'h4011, 16'h1234);
      nrst = 1'h0;
      step(2);
      nrst = 1'h1;
      rdc(16'h4011, 16'h0000);
      rdc(16'h4012, 16'h0009);
      rdc(16'h400C, 16'h002B);
   endtask : sc_reset
   initial begin
      nrst = 1'h0;
      nv_load = 1'h0;
      sh_v = 1'h1;
      st_a = 7'h22;
      sh_a = 7'h15;
      eng = '{FBR_LINK_UNDEF, FBR_NODE_INIT, 1'h1, 1'h0, 4'h0, 7'h33, 4'h6};
      nv_image = '0;
      repeat (6) @(posedge clk_sys);
      #2 nrst = 1'h1;
      sc_defaults();
      sc_status();
      sc_words();
      sc_source();
      sc_reset();
      report_and_stop();
   end
   initial begin
      clk_sys = 1'h0;
      forever #25 clk_sys = ~clk_sys;
   end
endmodule : fbr_regs_test
bind fbr_regs fbr_regs_properties chk_u (.clk_sys(clk_sys), .nrst(nrst),
   .mb_req(mb_req), .mb_rsp_q(mb_rsp_q), .eng(eng),
   .stored_node_addr(stored_node_addr),
   .shift_register_port_addr(shift_register_port_addr),
   .shift_register_port_valid(shift_register_port_valid),
   .apply_q(apply_q),
   .config_debug_port_invalid_q(config_debug_port_invalid_q),
   .nv_load(nv_load), .nv_image(nv_image), .nv_image_q(nv_image_q),
   .nv_store_q(nv_store_q));

// *** fbr_src_sel.sv ***
// fbr_src_sel: picks node address and bit rate from the selected source.
// assumes all inputs come from logic on the same clock; combinational.
`timescale 1ns/1ps
module fbr_src_sel
   import fbr_pkg::*;
(
   // selection
   input wire fbr_src_t src,
   // candidate settings
   input wire logic [6:0] stored_addr,
   input wire logic [15:0] stored_rate,
   input wire logic [6:0] shift_addr,
   input wire logic shift_valid,
   input wire logic [6:0] lss_addr,
   input wire logic [3:0] lss_rate,
   input wire logic bus_connected,
   // result
   output fbr_apply_t apply
);

   always_comb begin
      apply.addr = FBR_ADDR_NONE;
      apply.rate = FBR_RATE_AUTO;
      apply.invalid = 1'b0;
      case (src)
         FBR_SRC_STORED: begin
            apply.addr = stored_addr;
            apply.rate = stored_rate[3:0];
            apply.invalid = !fbr_rate_ok(stored_rate) ||
               (stored_addr == FBR_ADDR_NONE);
         end
         FBR_SRC_SHIFT: begin
            // shift register port sets the address, rate auto detected
            apply.addr = shift_addr;
            apply.invalid = !shift_valid;
         end
         FBR_SRC_LSS: begin
            // no network: address shows zero, setting invalid
            apply.addr = bus_connected ? lss_addr : FBR_ADDR_NONE;
            apply.rate = lss_rate;
            apply.invalid = !bus_connected;
         end
         default: begin
            apply.invalid = 1'b1;
         end
      endcase
      if (apply.invalid) begin
         apply.addr = FBR_ADDR_NONE;
      end
   end

endmodule : fbr_src_sel
